// ### logic/dacgc_regs.vh
// Purpose: register map, fields and counts of the dac gain and input block
// Assumes: 4-bit register address, 9-bit data word
// Notes:   definitions only
`ifndef DACGC_REGS_VH
`define DACGC_REGS_VH
`define DACGC_ADDR_LEFT_GAIN   4'h0
`define DACGC_ADDR_RIGHT_GAIN  4'h1
`define DACGC_ADDR_CHAN_FUNC   4'h2
`define DACGC_ADDR_SER_FMT     4'h3
`define DACGC_GAIN_RESET       8'hff
`define DACGC_GAIN_SILENT      8'h00
`define DACGC_UPDATE_BIT       8
`define DACGC_CF_RESET         9'h000
`define DACGC_SF_RESET         9'h000
`define DACGC_CF_SOFT_SILENCE  0
`define DACGC_CF_EMPHASIS      1
`define DACGC_CF_LOW_POWER     2
`define DACGC_CF_FMT_LO        3
`define DACGC_CF_FMT_HI        5
`define DACGC_SF_PROTOCOL      0
`define DACGC_SF_SYNC_INVERT   1
`define DACGC_SF_FOLLOW_LEFT   2
`define DACGC_SF_PHASE_INVERT  4
`define DACGC_SF_BCLK_INVERT   5
`define DACGC_SF_ZERO_SILENCE  8
`define DACGC_IGNORE_SAMPLES   5'd16
`define DACGC_ZERO_RUN_LIMIT   11'd1024
`endif

// ### logic/dacgc_fifo.v
// Purpose: sample buffer between serial receiver and gain stage
// Assumes: depth is a power of two
// Notes:   first-word-fall-through, flush clears contents
`timescale 1ns/10ps
module dacgc_fifo #(
  parameter WIDTH = 49,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys_in,
  input  wire             rst_n_in,
  input  wire             en_in,
  input  wire             flush_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0]      wr_ptr_reg;
  reg [AW:0]      rd_ptr_reg;
  wire            full_w;
  wire            empty_w;
  assign full_w        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty_w       = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_out  = !full_w;
  assign out_valid_out = !empty_w;
  assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
  always @(posedge clk_sys_in) begin
    if (en_in && in_valid_in && !full_w) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
    end
  end
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else if (en_in) begin
      if (flush_in) begin
        wr_ptr_reg <= {(AW+1){1'b0}};
        rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
        if (in_valid_in && !full_w) begin
          wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, 1'b1};
        end
        if (out_ready_in && !empty_w) begin
          rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ### logic/dacgc_top.v
// Purpose: serial audio receiver, gain decode and control of a stereo dac
// Assumes: bit clock, frame sync and data are asynchronous pins, oversampled by clk_sys_in
// Notes:   register writes arrive as a 4-bit address and 9-bit word with a write strobe
`timescale 1ns/10ps
`include "dacgc_regs.vh"
module dacgc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        clk_en_in,
  input  wire        reg_wr_in,
  input  wire [3:0]  reg_addr_in,
  input  wire [8:0]  reg_wdata_in,
  input  wire [3:0]  reg_raddr_in,
  output reg  [8:0]  reg_rdata_out,
  input  wire        serial_bit_clock_in,
  input  wire        frame_sync_in,
  input  wire        serial_data_in,
  input  wire        sample_ready_in,
  output reg         sample_valid_out,
  output reg  [23:0] left_sample_out,
  output reg  [23:0] right_sample_out,
  output reg  [7:0]  left_gain_code_out,
  output reg  [7:0]  right_gain_code_out,
  output reg         soft_silence_out,
  output reg         emphasis_correction_out,
  output reg         low_power_out,
  output reg         midrail_out,
  output reg         phase_invert_out,
  output reg         zero_silence_out
);
  // format codes, ordered high field bit, protocol bit, middle, low
  localparam FMT_RJ16 = 4'h0, FMT_RJ20 = 4'h1, FMT_RJ24 = 4'h2, FMT_LJ24 = 4'h3;
  localparam FMT_I16  = 4'h4, FMT_I24  = 4'h5, FMT_I20  = 4'h6, FMT_LJ20 = 4'h7;
  localparam FMT_D16  = 4'h8, FMT_D20  = 4'h9, FMT_D24  = 4'ha, FMT_D32  = 4'hb;
  localparam FMT_LJ16 = 4'hc;
  localparam ST_IDLE  = 2'd0, ST_LEFT = 2'd1, ST_RIGHT = 2'd2;

  reg  [8:0]  chan_func_reg;
  reg  [8:0]  ser_fmt_reg;
  reg  [7:0]  left_hold_reg;
  reg  [7:0]  right_hold_reg;
  reg  [7:0]  left_live_reg;
  reg  [7:0]  right_live_reg;
  reg         update_pend_reg;
  reg  [2:0]  bclk_sync_reg;
  reg  [1:0]  fs_sync_reg;
  reg  [1:0]  din_sync_reg;
  reg         fs_prev_reg;
  reg  [1:0]  state_reg;
  reg  [5:0]  bit_cnt_reg;
  reg  [31:0] shift_reg;
  reg  [23:0] left_word_reg;
  reg         wr_valid_reg;
  reg  [47:0] wr_data_reg;
  reg         power_prev_reg;
  reg  [4:0]  ignore_cnt_reg;
  reg  [10:0] zero_cnt_reg;
  reg         zero_mute_reg;
  wire [3:0]  fmt_w;
  wire        is_dsp_w;
  wire        is_i2s_w;
  wire        is_lj_w;
  wire [5:0]  wlen_w;
  wire        bclk_rise_w;
  wire        fs_now_w;
  wire        fs_level_w;
  wire        fs_edge_w;
  wire        fs_dsp_rise_w;
  wire        fifo_in_ready_w;
  wire        fifo_out_valid_w;
  wire [47:0] fifo_out_data_w;
  wire        pop_w;
  wire        wr_cf_w;
  wire        wr_pd_w;
  wire [23:0] new_word_w;
  wire        sample_zero_w;
  wire [7:0]  left_gain_now_w;
  wire [7:0]  right_gain_now_w;

  // word length of the selected format; unlisted codes fall back to 24 bits
  function [5:0] fmt_len;
    input [3:0] code;
    begin
      case (code)
        FMT_RJ16, FMT_I16, FMT_D16, FMT_LJ16: fmt_len = 6'd16;
        FMT_RJ20, FMT_I20, FMT_LJ20, FMT_D20: fmt_len = 6'd20;
        FMT_D32:                              fmt_len = 6'd32;
        default:                              fmt_len = 6'd24;
      endcase
    end
  endfunction

  // align a shifted word to 24 bits; short words gain low zeros, 32-bit drops low byte
  function [23:0] align24;
    input [31:0] sh;
    input [5:0]  len;
    begin
      case (len)
        6'd16:   align24 = {sh[15:0], 8'h00};
        6'd20:   align24 = {sh[19:0], 4'h0};
        6'd32:   align24 = sh[31:8];
        default: align24 = sh[23:0];
      endcase
    end
  endfunction

  assign fmt_w    = {chan_func_reg[`DACGC_CF_FMT_HI], ser_fmt_reg[`DACGC_SF_PROTOCOL],
                     chan_func_reg[`DACGC_CF_FMT_HI-1:`DACGC_CF_FMT_LO]};
  assign is_dsp_w = (fmt_w[3:2] == 2'b10);
  assign is_i2s_w = (fmt_w == FMT_I16) || (fmt_w == FMT_I24) || (fmt_w == FMT_I20);
  assign is_lj_w  = (fmt_w == FMT_LJ24) || (fmt_w == FMT_LJ20) || (fmt_w == FMT_LJ16);
  assign wlen_w   = fmt_len(fmt_w);

  // the first stage is read only by the second; edges come from stages two and three
  assign bclk_rise_w = ser_fmt_reg[`DACGC_SF_BCLK_INVERT] ?
                       (bclk_sync_reg[2] && !bclk_sync_reg[1]) :
                       (!bclk_sync_reg[2] && bclk_sync_reg[1]);
  assign fs_now_w    = fs_sync_reg[1];
  // left word is sync high for justified modes, sync low for i2s; inversion flips both
  assign fs_level_w  = fs_now_w ^ ser_fmt_reg[`DACGC_SF_SYNC_INVERT] ^ is_i2s_w;
  assign fs_edge_w   = fs_now_w != fs_prev_reg;
  assign fs_dsp_rise_w = fs_now_w && !fs_prev_reg;

  assign wr_cf_w = reg_wr_in && (reg_addr_in == `DACGC_ADDR_CHAN_FUNC);
  assign wr_pd_w = wr_cf_w && reg_wdata_in[`DACGC_CF_LOW_POWER];

  dacgc_fifo #(
    .WIDTH (48),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .en_in         (clk_en_in),
    .flush_in      (low_power_out),
    .in_valid_in   (wr_valid_reg),
    .in_ready_out  (fifo_in_ready_w),
    .in_data_in    (wr_data_reg),
    .out_valid_out (fifo_out_valid_w),
    .out_ready_in  (pop_w),
    .out_data_out  (fifo_out_data_w)
  );

  // a sample leaves the buffer when the output slot is free or being taken
  assign pop_w = fifo_out_valid_w && (!sample_valid_out || sample_ready_in);
  assign new_word_w    = align24(shift_reg, wlen_w);
  assign sample_zero_w = (fifo_out_data_w[47:0] == 48'h0);
  // a pending update shows the held codes with the very sample that applies them
  assign left_gain_now_w  = update_pend_reg ? left_hold_reg : left_live_reg;
  assign right_gain_now_w = update_pend_reg ? right_hold_reg : right_live_reg;

  // registers and gain latches
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chan_func_reg   <= `DACGC_CF_RESET;
      ser_fmt_reg     <= `DACGC_SF_RESET;
      left_hold_reg   <= `DACGC_GAIN_RESET;
      right_hold_reg  <= `DACGC_GAIN_RESET;
      left_live_reg   <= `DACGC_GAIN_RESET;
      right_live_reg  <= `DACGC_GAIN_RESET;
      update_pend_reg <= 1'b0;
      reg_rdata_out   <= 9'h000;
    end else if (clk_en_in) begin
      if (wr_pd_w) begin
        // everything else returns to default, only the low power bit stays
        chan_func_reg  <= `DACGC_CF_RESET | (9'h001 << `DACGC_CF_LOW_POWER);
        ser_fmt_reg    <= `DACGC_SF_RESET;
        left_hold_reg  <= `DACGC_GAIN_RESET;
        right_hold_reg <= `DACGC_GAIN_RESET;
        left_live_reg  <= `DACGC_GAIN_RESET;
        right_live_reg <= `DACGC_GAIN_RESET;
        update_pend_reg <= 1'b0;
      end else begin
        if (reg_wr_in) begin
          case (reg_addr_in)
            `DACGC_ADDR_LEFT_GAIN:  left_hold_reg  <= reg_wdata_in[7:0];
            `DACGC_ADDR_RIGHT_GAIN: right_hold_reg <= reg_wdata_in[7:0];
            `DACGC_ADDR_CHAN_FUNC:  chan_func_reg  <= reg_wdata_in;
            `DACGC_ADDR_SER_FMT:    ser_fmt_reg    <= reg_wdata_in;
            default: ;
          endcase
        end
        // update bit is not stored; it arms a transfer at the next sample
        if (reg_wr_in && (reg_addr_in[3:1] == 3'b000) && reg_wdata_in[`DACGC_UPDATE_BIT]) begin
          update_pend_reg <= 1'b1;
        end else if (pop_w && update_pend_reg) begin
          left_live_reg   <= left_hold_reg;
          right_live_reg  <= right_hold_reg;
          update_pend_reg <= 1'b0;
        end
      end
      case (reg_raddr_in)
        `DACGC_ADDR_LEFT_GAIN:  reg_rdata_out <= {1'b0, left_hold_reg};
        `DACGC_ADDR_RIGHT_GAIN: reg_rdata_out <= {1'b0, right_hold_reg};
        `DACGC_ADDR_CHAN_FUNC:  reg_rdata_out <= chan_func_reg;
        `DACGC_ADDR_SER_FMT:    reg_rdata_out <= ser_fmt_reg;
        default:                reg_rdata_out <= 9'h000;
      endcase
    end
  end

  // pin synchronisers
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bclk_sync_reg <= 3'b000;
      fs_sync_reg   <= 2'b00;
      din_sync_reg  <= 2'b00;
    end else if (clk_en_in) begin
      bclk_sync_reg <= {bclk_sync_reg[1:0], serial_bit_clock_in};
      fs_sync_reg   <= {fs_sync_reg[0], frame_sync_in};
      din_sync_reg  <= {din_sync_reg[0], serial_data_in};
    end
  end

  // serial receiver; samples only on the active bit clock edge
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fs_prev_reg   <= 1'b0;
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 6'd0;
      shift_reg     <= 32'h0;
      left_word_reg <= 24'h0;
      wr_valid_reg  <= 1'b0;
      wr_data_reg   <= 48'h0;
    end else if (clk_en_in) begin
      // overflow drops the sample; a full buffer never blocks the pins
      if (wr_valid_reg && fifo_in_ready_w) begin
        wr_valid_reg <= 1'b0;
      end
      if (low_power_out) begin
        state_reg    <= ST_IDLE;
        wr_valid_reg <= 1'b0;
        fs_prev_reg  <= 1'b0;
      end else if (bclk_rise_w) begin
        fs_prev_reg <= fs_now_w;
        if (is_dsp_w) begin
          case (state_reg)
            ST_IDLE: begin
              if (fs_dsp_rise_w) begin
                if (ser_fmt_reg[`DACGC_SF_SYNC_INVERT]) begin
                  state_reg   <= ST_LEFT;
                  bit_cnt_reg <= 6'd0;
                end else begin
                  state_reg   <= ST_LEFT;
                  shift_reg   <= {31'h0, din_sync_reg[1]};
                  bit_cnt_reg <= 6'd1;
                end
              end
            end
            ST_LEFT, ST_RIGHT: begin
              if (bit_cnt_reg == wlen_w) begin
                // words run back to back, so this edge carries the next first bit
                shift_reg   <= {31'h0, din_sync_reg[1]};
                bit_cnt_reg <= 6'd1;
                if (state_reg == ST_LEFT) begin
                  left_word_reg <= new_word_w;
                  state_reg     <= ST_RIGHT;
                end else begin
                  wr_data_reg  <= {left_word_reg, new_word_w};
                  wr_valid_reg <= 1'b1;
                  state_reg    <= ST_IDLE;
                end
              end else begin
                shift_reg   <= {shift_reg[30:0], din_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 6'd1;
              end
            end
            default: state_reg <= ST_IDLE;
          endcase
        end else if (fs_edge_w) begin
          // channel change: finish the previous word, right-justified keeps the last bits
          if (!fs_level_w) begin
            left_word_reg <= new_word_w;
          end else if (state_reg == ST_RIGHT) begin
            wr_data_reg  <= {left_word_reg, new_word_w};
            wr_valid_reg <= 1'b1;
          end
          state_reg <= fs_level_w ? ST_LEFT : ST_RIGHT;
          // i2s lags one bit; left-justified takes its msb on this edge
          if (is_i2s_w) begin
            shift_reg   <= 32'h0;
            bit_cnt_reg <= 6'd0;
          end else begin
            shift_reg   <= {31'h0, din_sync_reg[1]};
            bit_cnt_reg <= 6'd1;
          end
        end else if (!is_lj_w && !is_i2s_w) begin
          shift_reg <= {shift_reg[30:0], din_sync_reg[1]};
        end else if (bit_cnt_reg < wlen_w) begin
          shift_reg   <= {shift_reg[30:0], din_sync_reg[1]};
          bit_cnt_reg <= bit_cnt_reg + 6'd1;
        end
      end
    end
  end

  // output stage, power sequencing and zero-run detection
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_valid_out        <= 1'b0;
      left_sample_out         <= 24'h0;
      right_sample_out        <= 24'h0;
      left_gain_code_out      <= `DACGC_GAIN_RESET;
      right_gain_code_out     <= `DACGC_GAIN_RESET;
      soft_silence_out        <= 1'b0;
      emphasis_correction_out <= 1'b0;
      low_power_out           <= 1'b0;
      midrail_out             <= 1'b0;
      phase_invert_out        <= 1'b0;
      zero_silence_out        <= 1'b0;
      power_prev_reg          <= 1'b0;
      ignore_cnt_reg          <= 5'd0;
      zero_cnt_reg            <= 11'd0;
      zero_mute_reg           <= 1'b0;
    end else if (clk_en_in) begin
      low_power_out           <= chan_func_reg[`DACGC_CF_LOW_POWER];
      midrail_out             <= chan_func_reg[`DACGC_CF_LOW_POWER];
      soft_silence_out        <= chan_func_reg[`DACGC_CF_SOFT_SILENCE];
      emphasis_correction_out <= chan_func_reg[`DACGC_CF_EMPHASIS];
      phase_invert_out        <= ser_fmt_reg[`DACGC_SF_PHASE_INVERT];
      power_prev_reg          <= low_power_out;
      zero_silence_out        <= zero_mute_reg;
      if (sample_valid_out && sample_ready_in) begin
        sample_valid_out <= 1'b0;
      end
      if (low_power_out) begin
        sample_valid_out <= 1'b0;
        left_sample_out  <= 24'h0;
        right_sample_out <= 24'h0;
        zero_cnt_reg     <= 11'd0;
        zero_mute_reg    <= 1'b0;
      end else if (power_prev_reg) begin
        ignore_cnt_reg <= `DACGC_IGNORE_SAMPLES;
      end else if (pop_w) begin
        if (ignore_cnt_reg != 5'd0) begin
          ignore_cnt_reg <= ignore_cnt_reg - 5'd1;
        end else begin
          sample_valid_out   <= 1'b1;
          left_sample_out    <= fifo_out_data_w[47:24];
          right_sample_out   <= fifo_out_data_w[23:0];
          left_gain_code_out <= left_gain_now_w;
          right_gain_code_out <= ser_fmt_reg[`DACGC_SF_FOLLOW_LEFT] ?
                                 left_gain_now_w : right_gain_now_w;
          if (!sample_zero_w) begin
            zero_cnt_reg  <= 11'd0;
            zero_mute_reg <= 1'b0;
          end else if (zero_cnt_reg != `DACGC_ZERO_RUN_LIMIT) begin
            zero_cnt_reg <= zero_cnt_reg + 11'd1;
          end else begin
            zero_mute_reg <= ser_fmt_reg[`DACGC_SF_ZERO_SILENCE];
          end
        end
      end
      if (!ser_fmt_reg[`DACGC_SF_ZERO_SILENCE]) begin
        zero_mute_reg <= 1'b0;
      end
    end
  end
endmodule

// ### bench/dacgc_asserts.sv
// Purpose: port checks of dacgc_top
// Assumes: clk_en_in held high by the bench
// Notes: bound below the module
`timescale 1ns/10ps
module dacgc_asserts #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input wire        clk_sys_in,
  input wire        rst_n_in,
  input wire        clk_en_in,
  input wire        reg_wr_in,
  input wire [3:0]  reg_addr_in,
  input wire [8:0]  reg_wdata_in,
  input wire        sample_ready_in,
  input wire        sample_valid_out,
  input wire [23:0] left_sample_out,
  input wire [23:0] right_sample_out,
  input wire [7:0]  left_gain_code_out,
  input wire [7:0]  right_gain_code_out,
  input wire        soft_silence_out,
  input wire        emphasis_correction_out,
  input wire        low_power_out,
  input wire        midrail_out,
  input wire        phase_invert_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_cf_wr; clk_en_in && reg_wr_in && reg_addr_in == 4'h2; endsequence
  sequence s_sf_wr; clk_en_in && reg_wr_in && reg_addr_in == 4'h3; endsequence
  sequence s_lp_wr; s_cf_wr ##0 reg_wdata_in[2]; endsequence
  property p_soft;
    (s_cf_wr ##0 !reg_wdata_in[2]) |-> ##2 soft_silence_out == $past(reg_wdata_in[0], 2);
  endproperty
  a_soft: assert property (p_soft) else $error("soft silence off");
  property p_emph;
    (s_cf_wr ##0 !reg_wdata_in[2]) |-> ##2
      emphasis_correction_out == $past(reg_wdata_in[1], 2);
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis off");
  property p_lp_enter;
    s_lp_wr |-> ##2 low_power_out && midrail_out;
  endproperty
  a_lp_enter: assert property (p_lp_enter) else $error("low power late");
  property p_lp_clear;
    s_lp_wr |-> ##2 !soft_silence_out && !emphasis_correction_out && !phase_invert_out;
  endproperty
  a_lp_clear: assert property (p_lp_clear) else $error("controls kept");
  // three cycles let the flush land before valid is judged
  property p_lp_flush;
    low_power_out [*3] |-> !sample_valid_out;
  endproperty
  a_lp_flush: assert property (p_lp_flush) else $error("sample in low power");
  property p_phase;
    s_sf_wr |-> ##2 phase_invert_out == $past(reg_wdata_in[4], 2);
  endproperty
  a_phase: assert property (p_phase) else $error("phase off");
  property p_reset_gain;
    $rose(rst_n_in) |-> left_gain_code_out == 8'hff && right_gain_code_out == 8'hff;
  endproperty
  a_reset_gain: assert property (p_reset_gain) else $error("gain not ff");
  property p_hold;
    sample_valid_out && !sample_ready_in && !low_power_out
      |=> sample_valid_out && $stable(left_sample_out);
  endproperty
  a_hold: assert property (p_hold) else $error("sample dropped");
  property p_gain_step;
    $changed(left_gain_code_out) || $changed(right_gain_code_out)
      |-> sample_valid_out || low_power_out;
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain moved alone");
endmodule
bind dacgc_top dacgc_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) dacgc_asserts_inst (.*);

// ### bench/dacgc_source.sv
// Purpose: serial pcm source in dsp and left-justified framing
// Assumes: 800 ns bit clock, idle between frames
// Notes: one trailing slot pads each frame
`timescale 1ns/10ps
module dacgc_source (
  input  wire inv_in,
  output wire bclk_out,
  output reg  sync_out,
  output reg  data_out
);
  reg raw_reg;
  assign bclk_out = raw_reg ^ inv_in;
  initial begin
    raw_reg = 1'b0;
    sync_out = 1'b0;
    data_out = 1'b0;
  end
  task send(input [31:0] l, input [31:0] r, input integer n, input integer early);
    integer i;
    begin
      #37;
      for (i = -early; i <= 2 * n; i = i + 1) begin
        raw_reg = 1'b0;
        sync_out = (i == -early);
        // outside the words the line toggles so a stale bit never looks valid
        data_out = (i < 0 || i == 2 * n) ? ~data_out : (i < n) ? l[n-1-i] : r[2*n-1-i];
        #400 raw_reg = 1'b1;
        #400;
      end
      raw_reg = 1'b0;
      sync_out = 1'b0;
    end
  endtask
  // left-justified: sync high carries the left word, msb on the first edge of each half
  task send_lj(input [31:0] l, input [31:0] r, input integer n);
    integer i;
    begin
      #37;
      for (i = 0; i <= 2 * n; i = i + 1) begin
        raw_reg = 1'b0;
        // the closing rise of sync ends the right word
        sync_out = (i < n) || (i == 2 * n);
        data_out = (i == 2 * n) ? ~data_out : (i < n) ? l[n-1-i] : r[2*n-1-i];
        #400 raw_reg = 1'b1;
        #400;
      end
      raw_reg = 1'b0;
      sync_out = 1'b0;
    end
  endtask
endmodule

// ### bench/tb.sv
// Purpose: register and stream checks of dacgc_top
// Assumes: dsp and left-justified framing from the source model
// Notes: zero-run automute is not run, it needs too many frames
`timescale 1ns/10ps
module tb;
  reg         clk_sys_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         reg_wr_in = 1'b0;
  reg  [3:0]  reg_addr_in = 4'h0;
  reg  [8:0]  reg_wdata_in = 9'h000;
  reg  [3:0]  reg_raddr_in = 4'h0;
  reg         sample_ready_in = 1'b0;
  reg         bclk_invert = 1'b0;
  wire [8:0]  reg_rdata_out;
  wire [23:0] left_sample_out, right_sample_out;
  wire [7:0]  left_gain_code_out, right_gain_code_out;
  wire        sample_valid_out, soft_silence_out, emphasis_correction_out;
  wire        low_power_out, midrail_out, phase_invert_out, bclk, sync, sdata;
  wire        zero_silence_out;
  integer     num_errors = 0;
  integer     tests_run = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  dacgc_source src_inst (.inv_in(bclk_invert), .bclk_out(bclk), .sync_out(sync),
    .data_out(sdata));
  dacgc_top dacgc_top_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_raddr_in(reg_raddr_in), .reg_rdata_out(reg_rdata_out), .serial_bit_clock_in(bclk),
    .frame_sync_in(sync), .serial_data_in(sdata), .sample_ready_in(sample_ready_in),
    .sample_valid_out(sample_valid_out), .left_sample_out(left_sample_out),
    .right_sample_out(right_sample_out), .left_gain_code_out(left_gain_code_out),
    .right_gain_code_out(right_gain_code_out), .soft_silence_out(soft_silence_out),
    .emphasis_correction_out(emphasis_correction_out), .low_power_out(low_power_out),
    .midrail_out(midrail_out), .phase_invert_out(phase_invert_out),
    .zero_silence_out(zero_silence_out));
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [8:0] d);
    begin
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      @(negedge clk_sys_in);
    end
  endtask
  task rd(input [3:0] a, input [8:0] exp);
    begin
      @(posedge clk_sys_in);
      reg_raddr_in <= a;
      repeat (2) @(negedge clk_sys_in);
      chk(reg_rdata_out, exp);
    end
  endtask
  // ready stays low until a pair is seen, so the hold path is exercised
  task take(input [23:0] l, input [23:0] r, input [7:0] gl, input [7:0] gr);
    integer k;
    begin
      for (k = 0; k < 2000 && sample_valid_out !== 1'b1; k = k + 1)
        @(negedge clk_sys_in);
      chk(sample_valid_out, 24'h1);
      chk(left_sample_out, l);
      chk(right_sample_out, r);
      chk(left_gain_code_out, gl);
      chk(right_gain_code_out, gr);
      @(posedge clk_sys_in);
      sample_ready_in <= 1'b1;
      @(posedge clk_sys_in);
      sample_ready_in <= 1'b0;
    end
  endtask
  task final_report;
    begin
      $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(4'h0, 9'h0ff);
    rd(4'h2, 9'h000);
    rd(4'h3, 9'h000);
    rd(4'h5, 9'h000);
    chk(left_gain_code_out, 24'hff);
    $display("test reset done");
    wr(4'h2, 9'h023);
    rd(4'h2, 9'h023);
    chk(soft_silence_out, 24'h1);
    chk(emphasis_correction_out, 24'h1);
    wr(4'h2, 9'h020);
    wr(4'h3, 9'h010);
    rd(4'h3, 9'h010);
    chk(phase_invert_out, 24'h1);
    chk(soft_silence_out, 24'h0);
    $display("test controls done");
    wr(4'h0, 9'h040);
    wr(4'h1, 9'h120);
    rd(4'h0, 9'h040);
    chk(left_gain_code_out, 24'hff);
    src_inst.send(32'h1234, 32'habcd, 16, 0);
    take(24'h123400, 24'habcd00, 8'h40, 8'h20);
    wr(4'h3, 9'h002);
    src_inst.send(32'h8001, 32'h7ffe, 16, 1);
    take(24'h800100, 24'h7ffe00, 8'h40, 8'h20);
    wr(4'h2, 9'h038);
    wr(4'h3, 9'h004);
    src_inst.send(32'h12345678, 32'h9abcdef0, 32, 0);
    take(24'h123456, 24'h9abcde, 8'h40, 8'h40);
    wr(4'h3, 9'h020);
    bclk_invert <= 1'b1;
    src_inst.send(32'h00ff00ff, 32'hff00ff00, 32, 0);
    take(24'h00ff00, 24'hff00ff, 8'h40, 8'h20);
    bclk_invert <= 1'b0;
    wr(4'h3, 9'h100);
    wr(4'h2, 9'h018);
    src_inst.send_lj(32'h123456, 32'hfedcba, 24);
    take(24'h123456, 24'hfedcba, 8'h40, 8'h20);
    chk(zero_silence_out, 24'h0);
    $display("test stream done");
    wr(4'h2, 9'h004);
    @(negedge clk_sys_in);
    chk(low_power_out & midrail_out, 24'h1);
    rd(4'h3, 9'h000);
    rd(4'h0, 9'h0ff);
    wr(4'h2, 9'h020);
    repeat (16) src_inst.send(32'h1, 32'h1, 16, 0);
    src_inst.send(32'h5555, 32'h2222, 16, 0);
    take(24'h555500, 24'h222200, 8'hff, 8'hff);
    $display("test low power done");
    final_report;
  end
endmodule
